// *** hdl/otp_wiper_ctrl.sv ***
// Purpose: Serial slave, wiper latch and one-time fuse programming control.
// Assumes: Fuse array is external; its sense lines are asynchronous levels.
// Notes: Only power-on reset exists; the fuse sense lines carry state over it.
//
// Contract
// [R1] Decode the 6-bit latch code to exactly one of 64 taps.
// [R2] Unprogrammed part loads midscale code 32 at every power-on.
// [R3] Before programming, any number of code writes update the wiper.
// [R4] Program flag set in a write burns fuses with the current code.
// [R5] Store is six data fuses, one test fuse and one lock fuse.
// [R6] After correct data burn, blow lock; then refuse writes and programming.
// [R7] Master issues the programming command only once per unit.
// [R8] Read transfers return both validation bits.
// [R9] Validation: 00 ready, 01 test fuse fail, 10 fatal, 11 programmed.
// [R10] Master should read validation bits back after programming.
// [R11] Programmed part loads the stored fuse code at each power-on.
// [R12] Code 0 is the low end terminal; each increment moves one tap up.
// [R13] Address select pin is compared with one address bit.
// [R14] Address byte is 010110, select pin value, then read/write bit.
// [R15] Write is address, instruction with program flag, data; read omits instruction.
// [R16] Read byte holds validation bits on top and wiper code below.
`timescale 1ns/1ps
`default_nettype none
module otp_wiper_ctrl #(
  parameter int P_BURN_CYCLES = otp_wiper_pkg::BURN_CYCLES
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Serial link and address select.
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_address_select_pin,
  // Fuse array sense and burn controls.
  input wire logic [otp_wiper_pkg::CODE_W-1:0] i_fuse_data_sense,
  input wire logic i_fuse_test_sense,
  input wire logic i_fuse_lock_sense,
  output logic o_fuse_burn_data_en,
  output logic [otp_wiper_pkg::CODE_W-1:0] o_fuse_burn_code,
  output logic o_fuse_burn_lock_en,
  // Wiper and status.
  output logic [otp_wiper_pkg::TAP_COUNT-1:0] o_tap_select,
  output logic [otp_wiper_pkg::CODE_W-1:0] o_wiper_code,
  output logic o_validation_high,
  output logic o_validation_low,
  output logic o_busy
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INSTR, ST_DATA, ST_READ, ST_HOLD} link_e;
  typedef enum logic [2:0] {B_IDLE, B_DATA, B_CHECK, B_LOCK, B_DONE} burn_e;

  logic [1:0] scl_sync_reg, sda_sync_reg, sel_sync_reg, test_sync_reg, lock_sync_reg;
  logic [otp_wiper_pkg::CODE_W-1:0] data_sync1_reg, data_sync2_reg;
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  link_e link_reg;
  burn_e burn_reg;
  logic [3:0] bit_cnt_reg;
  logic ack_phase_reg;
  logic [7:0] rx_reg, tx_reg;
  logic prog_flag_reg, write_ok_reg, attempted_reg, por_done_reg;
  logic start_burn;
  logic [2:0] settle_reg;
  logic [31:0] burn_cnt_reg;
  logic locked;
  logic [1:0] val_next;
  logic [7:0] read_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin and fuse sense line.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sel_sync_reg <= 2'h0;
      test_sync_reg <= 2'h0;
      lock_sync_reg <= 2'h0;
      data_sync1_reg <= 6'h00;
      data_sync2_reg <= 6'h00;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda_in};
      sel_sync_reg <= {sel_sync_reg[0], i_address_select_pin};
      test_sync_reg <= {test_sync_reg[0], i_fuse_test_sense};
      lock_sync_reg <= {lock_sync_reg[0], i_fuse_lock_sense};
      data_sync1_reg <= i_fuse_data_sense;
      data_sync2_reg <= data_sync1_reg;
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // Edges and bus conditions are taken only from the second flop stage.
  assign scl_rise = scl_sync_reg[1] && !scl_d_reg;
  assign scl_fall = !scl_sync_reg[1] && scl_d_reg;
  assign start_cond = scl_sync_reg[1] && scl_d_reg && !sda_sync_reg[1] && sda_d_reg;
  assign stop_cond = scl_sync_reg[1] && scl_d_reg && sda_sync_reg[1] && !sda_d_reg;

  // A blown lock fuse or any earlier attempt closes the part to changes.
  assign locked = lock_sync_reg[1] || attempted_reg || (burn_reg != B_IDLE); // see [R6] see [R7]
  assign read_byte = {val_next, o_wiper_code}; // see [R8] see [R16]

  ////////////////////////////////////////////////////////////////////////////
  // Validation bits come from the sensed fuses and the attempt flag.
  always_comb begin
    if (lock_sync_reg[1]) begin
      val_next = otp_wiper_pkg::VAL_DONE; // see [R9]
    end else if (!test_sync_reg[1]) begin
      val_next = attempted_reg ? otp_wiper_pkg::VAL_TEST_FAIL : otp_wiper_pkg::VAL_READY;
    end else begin
      val_next = otp_wiper_pkg::VAL_FATAL; // see [R9]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_validation_high <= 1'b0;
      o_validation_low <= 1'b0;
    end else begin
      o_validation_high <= val_next[1];
      o_validation_low <= val_next[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave: bytes are sampled on rising clock, the line changes on falling clock.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      link_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      o_sda_oe <= 1'b0;
      prog_flag_reg <= 1'b0;
      write_ok_reg <= 1'b0;
    end else if (start_cond) begin
      link_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (stop_cond) begin
      link_reg <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (link_reg == ST_READ) begin
      if (scl_rise && ack_phase_reg && sda_sync_reg[1]) begin
        link_reg <= ST_HOLD; // Master did not acknowledge: stop sending.
      end else if (scl_rise && !ack_phase_reg) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_fall && ack_phase_reg) begin
        ack_phase_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        tx_reg <= read_byte;
        o_sda_oe <= !read_byte[7];
      end else if (scl_fall && bit_cnt_reg == otp_wiper_pkg::BYTE_BITS) begin
        ack_phase_reg <= 1'b1;
        o_sda_oe <= 1'b0;
      end else if (scl_fall) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
        o_sda_oe <= !tx_reg[6];
      end
    end else if (link_reg != ST_IDLE && link_reg != ST_HOLD) begin
      if (scl_rise && bit_cnt_reg != otp_wiper_pkg::BYTE_BITS) begin
        rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_fall && bit_cnt_reg == otp_wiper_pkg::BYTE_BITS && !ack_phase_reg) begin
        ack_phase_reg <= 1'b1;
        case (link_reg)
          ST_ADDR: begin
            if (rx_reg[7:1] == {otp_wiper_pkg::ADDR_PREFIX, sel_sync_reg[1]}) begin
              o_sda_oe <= 1'b1; // see [R13] see [R14]
            end else begin
              link_reg <= ST_HOLD;
            end
          end
          ST_INSTR: begin
            prog_flag_reg <= rx_reg[otp_wiper_pkg::PROG_FLAG_BIT]; // see [R15]
            o_sda_oe <= 1'b1;
          end
          ST_DATA: begin
            write_ok_reg <= !locked;
            o_sda_oe <= !locked; // Refused data byte is not acknowledged, see [R6].
          end
          default: begin
            link_reg <= ST_HOLD;
          end
        endcase
      end else if (scl_fall && ack_phase_reg) begin
        ack_phase_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        write_ok_reg <= 1'b0;
        case (link_reg)
          ST_ADDR: begin
            if (rx_reg[otp_wiper_pkg::RW_BIT]) begin
              link_reg <= ST_READ; // see [R15]
              tx_reg <= read_byte;
              o_sda_oe <= !read_byte[7];
            end else begin
              link_reg <= ST_INSTR;
              o_sda_oe <= 1'b0;
            end
          end
          ST_INSTR: begin
            link_reg <= ST_DATA;
            o_sda_oe <= 1'b0;
          end
          default: begin
            link_reg <= ST_HOLD; // Further bytes of a write are ignored.
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // The data byte is committed when its acknowledge ends.
  assign start_burn = write_ok_reg && scl_fall && ack_phase_reg && prog_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wiper latch: midscale or stored code at power-on, free writes until locked.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_wiper_code <= otp_wiper_pkg::MIDSCALE_CODE; // see [R2]
      por_done_reg <= 1'b0;
      settle_reg <= 3'h0;
    end else if (!por_done_reg) begin
      // Wait until the fuse sense lines have crossed their synchronisers.
      settle_reg <= settle_reg + 3'h1;
      if (settle_reg == otp_wiper_pkg::SETTLE_CYCLES) begin
        por_done_reg <= 1'b1;
        if (lock_sync_reg[1]) begin
          o_wiper_code <= data_sync2_reg; // see [R11]
        end
      end
    end else if (write_ok_reg && scl_fall && ack_phase_reg) begin
      o_wiper_code <= rx_reg[otp_wiper_pkg::CODE_W-1:0]; // see [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse burn: data and test fuses first, lock fuse only if the data reads back right.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      burn_reg <= B_IDLE;
      burn_cnt_reg <= 32'h0;
      attempted_reg <= 1'b0;
      o_fuse_burn_data_en <= 1'b0;
      o_fuse_burn_lock_en <= 1'b0;
      o_fuse_burn_code <= 6'h00;
    end else begin
      case (burn_reg)
        B_IDLE: begin
          if (start_burn) begin
            burn_reg <= B_DATA; // see [R4] see [R5]
            attempted_reg <= 1'b1;
            o_fuse_burn_code <= rx_reg[otp_wiper_pkg::CODE_W-1:0];
            o_fuse_burn_data_en <= 1'b1;
            burn_cnt_reg <= 32'h0;
          end
        end
        B_DATA, B_LOCK: begin
          burn_cnt_reg <= burn_cnt_reg + 32'h1;
          if (burn_cnt_reg == 32'(P_BURN_CYCLES - 1)) begin
            o_fuse_burn_data_en <= 1'b0;
            o_fuse_burn_lock_en <= 1'b0;
            burn_cnt_reg <= 32'h0;
            burn_reg <= (burn_reg == B_DATA) ? B_CHECK : B_DONE;
          end
        end
        B_CHECK: begin
          burn_cnt_reg <= burn_cnt_reg + 32'h1;
          if (burn_cnt_reg == 32'(otp_wiper_pkg::SETTLE_CYCLES)) begin
            burn_cnt_reg <= 32'h0;
            if (test_sync_reg[1] && data_sync2_reg == o_fuse_burn_code) begin
              burn_reg <= B_LOCK; // see [R6]
              o_fuse_burn_lock_en <= 1'b1;
            end else begin
              burn_reg <= B_DONE;
            end
          end
        end
        B_DONE: begin
          burn_reg <= B_DONE; // One attempt only until the next power-on.
        end
        default: begin
          burn_reg <= B_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_busy <= start_burn || (burn_reg == B_DATA) || (burn_reg == B_CHECK) || (burn_reg == B_LOCK);
      o_sda_out <= 1'b0; // Open drain: the line is only ever pulled low.
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tap decoder drives the ladder switches.
  otp_tap_decoder u_dec (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_code(o_wiper_code),
    .o_tap_select(o_tap_select)
  );
endmodule
`default_nettype wire

// *** include/otp_wiper_pkg.sv ***
// Purpose: Shared constants for the one-time-programmable wiper setting control.
// Assumes: 100 MHz system clock; serial link sampled by the system clock.
// Notes: Fuse burn time is long, so the top module takes its cycle count as a parameter.
package otp_wiper_pkg;
  // Wiper code width and number of tap positions on the resistor ladder.
  localparam int CODE_W = 6;
  localparam int TAP_COUNT = 64;
  // Midscale code loaded at power-on while the part is unprogrammed.
  localparam logic [5:0] MIDSCALE_CODE = 6'h20;
  // Fixed upper six bits of the slave address byte.
  localparam logic [5:0] ADDR_PREFIX = 6'h16;
  // Bit positions inside the address and instruction bytes.
  localparam int RW_BIT = 0;
  localparam int PROG_FLAG_BIT = 7;
  // Bits in a serial byte and the value of the bit counter once a byte is in.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Validation codes {validation_high, validation_low}.
  localparam logic [1:0] VAL_READY = 2'h0;
  localparam logic [1:0] VAL_TEST_FAIL = 2'h1;
  localparam logic [1:0] VAL_FATAL = 2'h2;
  localparam logic [1:0] VAL_DONE = 2'h3;
  // Timing: system clock in kHz, fuse burn time in ms, derived cycle count.
  localparam int CLK_KHZ = 100000;
  localparam int BURN_TIME_MS = 400;
  localparam int BURN_CYCLES = BURN_TIME_MS * CLK_KHZ;
  // Cycles allowed for fuse sense lines to pass their synchronisers.
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;
endpackage

// *** hdl/otp_tap_decoder.sv ***
// Purpose: Decode the wiper code into a one-hot tap select for the resistor ladder.
// Assumes: Code arrives from logic on the same clock.
// Notes: Output is registered so the ladder switches see no decode glitches.
`timescale 1ns/1ps
`default_nettype none
module otp_tap_decoder (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Wiper code in, tap select out.
  input wire logic [otp_wiper_pkg::CODE_W-1:0] i_code,
  output logic [otp_wiper_pkg::TAP_COUNT-1:0] o_tap_select
);
  ////////////////////////////////////////////////////////////////////////////
  // One flop per tap; tap 0 is the low end terminal, each step one tap up.
  genvar g;
  generate
    for (g = 0; g < otp_wiper_pkg::TAP_COUNT; g = g + 1) begin : g_tap
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          o_tap_select[g] <= (g == int'(otp_wiper_pkg::MIDSCALE_CODE));
        end else begin
          o_tap_select[g] <= (int'(i_code) == g); // see [R1] see [R12]
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** tb/otp_wiper_props.sv ***
// Purpose: Port checker for the one-time-programmable wiper control.
// Assumes: Fuse sense lines hold steady between burns.
// Notes: The burn length is counted in helper logic, not by repetition.
`timescale 1ns/1ps
`default_nettype none
module otp_wiper_props #(
  parameter int P_BURN_CYCLES = 20
) (
  // Clock, reset and fuse array.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [5:0] i_fuse_data_sense,
  input wire logic i_fuse_test_sense,
  input wire logic i_fuse_lock_sense,
  input wire logic o_fuse_burn_data_en,
  input wire logic [5:0] o_fuse_burn_code,
  input wire logic o_fuse_burn_lock_en,
  // Wiper and status.
  input wire logic [63:0] o_tap_select,
  input wire logic [5:0] o_wiper_code,
  input wire logic o_validation_high,
  input wire logic o_validation_low,
  input wire logic o_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  int burn_cnt;
  logic tried;
  ////////////////////////////////////////////////////////////////////////////////
  // Burn length, and memory of an attempt since power-on, since a retry can ruin the part.
  always_ff @(posedge i_sys_clk) begin
    burn_cnt <= o_fuse_burn_data_en ? burn_cnt + 1 : 0;
    tried <= !i_rst_b ? 1'b0 : (tried | o_fuse_burn_data_en);
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_one_tap;
    $onehot(o_tap_select);
  endproperty
  a_one_tap: assert property (p_one_tap) else $error("tap select not one-hot");
  property p_tap_code;
    $stable(o_wiper_code) [*3] |-> o_tap_select[o_wiper_code] == 1'b1;
  endproperty
  a_tap_code: assert property (p_tap_code) else $error("tap does not follow code");
  property p_mid_start;
    $rose(i_rst_b) |-> o_wiper_code == otp_wiper_pkg::MIDSCALE_CODE;
  endproperty
  a_mid_start: assert property (p_mid_start) else $error("no midscale at power-on");
  property p_stored_load;
    $rose(i_rst_b) && i_fuse_lock_sense |-> ##[4:9] o_wiper_code == i_fuse_data_sense;
  endproperty
  a_stored_load: assert property (p_stored_load) else $error("stored code not loaded");
  property p_burn_len;
    $fell(o_fuse_burn_data_en) |-> burn_cnt == P_BURN_CYCLES;
  endproperty
  a_burn_len: assert property (p_burn_len) else $error("data burn length wrong");
  property p_lock_ok;
    $rose(o_fuse_burn_lock_en) |->
      i_fuse_test_sense && i_fuse_data_sense == o_fuse_burn_code && !o_fuse_burn_data_en;
  endproperty
  a_lock_ok: assert property (p_lock_ok) else $error("lock burn without good data");
  property p_one_try;
    $rose(o_fuse_burn_data_en) |-> !tried;
  endproperty
  a_one_try: assert property (p_one_try) else $error("second burn attempt");
  property p_busy;
    o_fuse_burn_data_en || o_fuse_burn_lock_en |-> o_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("burn while not busy");
  property p_val_done;
    i_fuse_lock_sense [*5] |-> {o_validation_high, o_validation_low} == otp_wiper_pkg::VAL_DONE;
  endproperty
  a_val_done: assert property (p_val_done) else $error("locked part not reported done");
endmodule
`default_nettype wire

// *** tb/otp_i2c_master.sv ***
// Purpose: Two-wire bus master driving the wiper control.
// Assumes: SDA has a pull-up; this model only pulls low.
// Notes: SCL stands high between transfers and low between frames; one quarter period is 20 ns.
`timescale 1ns/1ps
`default_nettype none
module otp_i2c_master (
  // Clock and wire level.
  input wire logic i_sys_clk,
  input wire logic i_sda,
  // Master drive.
  output logic o_scl,
  output logic o_sda_low
);
  // Both lines start released.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Quarter of the SCL period, changed just after a clock edge.
  task automatic q();
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  // Start and stop conditions: SDA moves while SCL is high.
  task automatic start();
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
    q();
  endtask
  // Nine clocks MSB first; a one releases SDA so the device may drive it.
  task automatic frame9(input logic [8:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      o_sda_low = ~b[i];
      q();
      o_scl = 1'b1;
      q();
      r[i] = i_sda;
      q();
      o_scl = 1'b0;
      q();
    end
  endtask
  // Write is address, instruction, data; read omits the instruction and ends in a NACK.
  task automatic write3(input logic sel, input logic [7:0] ins, input logic [7:0] d,
                        output logic [2:0] acks);
    logic [8:0] r0, r1, r2;
    start();
    frame9({otp_wiper_pkg::ADDR_PREFIX, sel, 1'b0, 1'b1}, r0);
    frame9({ins, 1'b1}, r1);
    frame9({d, 1'b1}, r2);
    stop();
    acks = {~r0[0], ~r1[0], ~r2[0]};
  endtask
  task automatic read1(input logic sel, output logic ack, output logic [7:0] d);
    logic [8:0] r0, r1;
    start();
    frame9({otp_wiper_pkg::ADDR_PREFIX, sel, 1'b1, 1'b1}, r0);
    frame9(9'h1ff, r1);
    stop();
    ack = ~r0[0];
    d = r1[8:1];
  endtask
endmodule
`default_nettype wire

// *** tb/otp_wiper_setting_control_bench.sv ***
// Purpose: Self-checking bench for the wiper control.
// Assumes: Burn length shortened to 20 cycles; fuse array modelled here.
// Notes: Each fresh fuse state stands for a new unit.
`timescale 1ns/1ps
`default_nettype none
module otp_wiper_setting_control_bench;
  localparam int P_BURN_CYCLES = 20;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic sel = 1'b0;
  logic broken = 1'b0;
  logic [5:0] fd = 6'h00;
  logic ft = 1'b0;
  logic fl = 1'b0;
  wire scl, m_low, oe, sda, sda_out, burn_d, burn_l, busy, vh, vl;
  wire [5:0] burn_code, code;
  wire [63:0] taps;
  int bad_count = 0;
  int n_compared = 0;
  int seed = 44;
  logic [2:0] acks;
  logic ack;
  logic [7:0] rd;
  logic [5:0] c;
  logic [5:0] corner [3] = '{6'h00, 6'h01, 6'h3f};
  // Clock at 100 MHz.
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Open-drain SDA with pull-up; the device's level counts only while it is enabled.
  assign sda = ~m_low & (oe ? sda_out : 1'b1);
  otp_wiper_ctrl #(.P_BURN_CYCLES(P_BURN_CYCLES)) dut (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
    .i_address_select_pin(sel), .i_fuse_data_sense(fd), .i_fuse_test_sense(ft),
    .i_fuse_lock_sense(fl), .o_fuse_burn_data_en(burn_d), .o_fuse_burn_code(burn_code),
    .o_fuse_burn_lock_en(burn_l), .o_tap_select(taps), .o_wiper_code(code),
    .o_validation_high(vh), .o_validation_low(vl), .o_busy(busy));
  otp_i2c_master m (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
  // Fuse array: a burn sets the sensed state; a broken part never blows its test fuse.
  always @(posedge i_sys_clk) begin
    if (burn_d) begin
      fd <= burn_code;
      ft <= ~broken;
    end
    if (burn_l) fl <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] exp_tap(input logic [5:0] v);
    return 64'h1 << v;
  endfunction
  function automatic logic [7:0] exp_byte(input logic [1:0] val, input logic [5:0] v);
    return {val, v};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Power-on is the only reset; fuse sense lines keep their state across it.
  task automatic power_on();
    i_rst_b = 1'b0;
    repeat (20) @(posedge i_sys_clk);
    #1 i_rst_b = 1'b1;
    repeat (12) @(posedge i_sys_clk);
    #1;
  endtask
  // Program attempt, then a bounded wait for the burn and check to finish.
  task automatic prog_unit(input logic [5:0] v);
    m.write3(sel, 8'h80, {2'h0, v}, acks);
    for (int k = 0; k < 300 && busy !== 1'b0; k++)
      @(posedge i_sys_clk);
    #1;
    chk8(8'(busy), 8'h00);
  endtask
  // Watchdog far beyond the expected run length.
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    sel = 1'($random(seed));
    power_on();
    chk8(8'(code), 8'h20);
    chk64(taps, exp_tap(6'h20));
    m.read1(sel, ack, rd);
    chk8(8'(ack), 8'h01);
    chk8(rd, exp_byte(otp_wiper_pkg::VAL_READY, 6'h20));
    m.write3(~sel, 8'h00, 8'h05, acks);
    chk8(8'(acks), 8'h00);
    chk8(8'(code), 8'h20);
    for (int i = 0; i < 12; i++) begin
      c = (i < 3) ? corner[i] : 6'($random(seed));
      m.write3(sel, 8'($random(seed)) & 8'h7f, {2'h0, c}, acks);
      repeat (4) @(posedge i_sys_clk);
      chk8(8'(acks), 8'h07);
      chk8(8'(code), 8'(c));
      chk64(taps, exp_tap(c));
    end
    c = 6'($random(seed));
    prog_unit(c);
    chk8(8'(burn_code), 8'(c));
    chk8(8'({vh, vl}), 8'(otp_wiper_pkg::VAL_DONE));
    m.read1(sel, ack, rd);
    chk8(rd, exp_byte(otp_wiper_pkg::VAL_DONE, c));
    m.write3(sel, 8'h80, {2'h0, ~c}, acks);
    repeat (4) @(posedge i_sys_clk);
    chk8(8'(acks), 8'h06);
    chk8(8'(code), 8'(c));
    power_on();
    chk8(8'(code), 8'(c));
    chk64(taps, exp_tap(c));
    fd = 6'h00;
    fl = 1'b0;
    ft = 1'b0;
    broken = 1'b1;
    power_on();
    prog_unit(6'h2a);
    chk8(8'({vh, vl}), 8'(otp_wiper_pkg::VAL_TEST_FAIL));
    ft = 1'b1;
    power_on();
    chk8(8'({vh, vl}), 8'(otp_wiper_pkg::VAL_FATAL));
    tally_and_finish();
  end
endmodule
bind otp_wiper_ctrl otp_wiper_props #(.P_BURN_CYCLES(P_BURN_CYCLES)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_fuse_data_sense(i_fuse_data_sense),
  .i_fuse_test_sense(i_fuse_test_sense), .i_fuse_lock_sense(i_fuse_lock_sense),
  .o_fuse_burn_data_en(o_fuse_burn_data_en), .o_fuse_burn_code(o_fuse_burn_code),
  .o_fuse_burn_lock_en(o_fuse_burn_lock_en), .o_tap_select(o_tap_select),
  .o_wiper_code(o_wiper_code), .o_validation_high(o_validation_high),
  .o_validation_low(o_validation_low), .o_busy(o_busy));
`default_nettype wire
